/* pfsr_top.sv */
// Overview of operation
// - six functions per pad, select holds number minus one
// - plain inputs still follow pad when unselected
// - default-high inputs see one when unselected
// - default-low inputs see zero when unselected
// - bidir default-high: peripheral owns pad, else one
// - two-bit drive strength per pad, resets to two
// - reset disables drivers, ie and pulls at defaults
// - after reset function one selected, drives enable
// - pads 34 to 39 input-only, no pulls
// - matrix connects any signal to any pad, but drives only pads 0 to 33
// - some inputs reachable by direct path or matrix
// - management and carrier signals routable to any pad
// - always-on pads work asleep and can wake
// - regulator voltage from strap and fuse, software overrides
// - unassigned routed input sees its default, then invert
`timescale 1ns/10ps
`default_nettype none

module pfsr_top #(
  parameter pfsr_pkg::pfsr_ftype_e [pfsr_pkg::NPAD-1:0][pfsr_pkg::NFUNC-1:0] PAD_FTYPE =
    '{default: pfsr_pkg::ft_bidir} // kind of each pad function
) (
  input wire logic clock, // system clock, 10 MHz
  input wire logic nrst, // asynchronous reset, active low
  // per-pad configuration write
  input wire logic pad_cfg_wr, // write strobe for one pad
  input wire logic [pfsr_pkg::PAD_W-1:0] pad_cfg_idx, // pad number
  input wire logic [pfsr_pkg::FSEL_W-1:0] pad_cfg_fsel, // function number minus one
  input wire logic [pfsr_pkg::DRV_W-1:0] pad_cfg_drive, // drive strength code
  input wire logic pad_cfg_ie, // input enable
  input wire logic pad_cfg_pu, // weak pull-up
  input wire logic pad_cfg_pd, // weak pull-down
  input wire logic pad_cfg_route_en, // output from matrix
  input wire logic [pfsr_pkg::SIG_W-1:0] pad_cfg_route_sig, // matrix signal number
  input wire logic pad_cfg_wake_en, // wake source enable
  // per-signal routed input configuration write
  input wire logic sig_cfg_wr, // write strobe for one signal
  input wire logic [pfsr_pkg::SIG_W-1:0] sig_cfg_idx, // signal number
  input wire logic [pfsr_pkg::PAD_W-1:0] routed_input_select, // pad, 40 and above none
  input wire logic routed_input_invert, // invert the input
  input wire logic sig_cfg_route, // use matrix instead of direct path
  // regulator voltage
  input wire logic strap_vsel, // strap pin, high selects 1.8 V
  input wire logic fuse_force, // fuse overrides the strap
  input wire logic fuse_vsel, // fuse voltage choice
  input wire logic vsel_wr, // software override strobe
  input wire logic vsel_val, // software voltage choice
  input wire logic deep_sleep, // chip in deep sleep
  // pad side
  input wire logic [pfsr_pkg::NPAD-1:0] pad_in, // pad input levels
  output logic [pfsr_pkg::NPAD-1:0] pad_out, // pad output levels
  output logic [pfsr_pkg::NPAD-1:0] pad_oe_n, // output enables, low drives
  output logic [pfsr_pkg::NPAD-1:0] pad_ie, // input enables
  output logic [pfsr_pkg::NPAD-1:0] pad_pu, // weak pull-ups
  output logic [pfsr_pkg::NPAD-1:0] pad_pd, // weak pull-downs
  output logic [pfsr_pkg::NPAD-1:0][pfsr_pkg::DRV_W-1:0] pad_drive, // drive codes
  // peripheral side
  input wire logic [pfsr_pkg::NPAD-1:0][pfsr_pkg::NFUNC-1:0] func_out, // direct outputs
  input wire logic [pfsr_pkg::NPAD-1:0][pfsr_pkg::NFUNC-1:0] func_oe, // direct enables
  output logic [pfsr_pkg::NPAD-1:0][pfsr_pkg::NFUNC-1:0] func_in, // direct inputs
  input wire logic [pfsr_pkg::NSIG-1:0] sig_out, // matrix outputs
  input wire logic [pfsr_pkg::NSIG-1:0] sig_oe, // matrix output enables
  output logic [pfsr_pkg::NSIG-1:0] routed_in, // matrix inputs
  output logic io_supply_regulator_sel, // regulator at 1.8 V when high
  output logic wake // wake request from always-on pads
);

  logic [1:0] rst_sync; // reset release chain
  logic rst_n; // synchronised reset, active low
  pfsr_pkg::pfsr_state_s st; // registered state
  pfsr_pkg::pfsr_state_s next_st; // next state
  logic [pfsr_pkg::NSIG-1:0] direct_val; // direct path values
  logic [pfsr_pkg::NSIG-1:0] route_val; // selected routed input values

  // reset asserts at once and releases through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // per-signal input selection, matrix or direct path
  for (genvar s = 0; s < pfsr_pkg::NSIG; s++) begin : g_sig
    // direct path is live only while its pad selects the direct function
    assign direct_val[s] =
      ((st.in_sel[s] < pfsr_pkg::PAD_W'(pfsr_pkg::NPAD)) &&
       (st.fsel[st.in_sel[s]] == pfsr_pkg::DIRECT_FSEL)) ?
      pad_in[st.in_sel[s]] : pfsr_pkg::SIG_DEFAULT[s];
    pfsr_route_in u_route_in (
      .pad_in(pad_in),
      .sel(st.in_sel[s]),
      .inv(st.in_inv[s]),
      .route_en(st.in_route[s]),
      .both_path(pfsr_pkg::SIG_BOTH[s]),
      .dflt(pfsr_pkg::SIG_DEFAULT[s]),
      .direct_val(direct_val[s]),
      .val(route_val[s])
    );
  end

  // next state: configuration writes, pad drive and peripheral inputs
  always_comb begin
    logic [pfsr_pkg::FSEL_W-1:0] f;
    logic o;
    logic oe;
    f = '0;
    o = 1'b0;
    oe = 1'b0;
    next_st = st;
    // one pad's configuration per write
    if (pad_cfg_wr && (pad_cfg_idx < pfsr_pkg::PAD_W'(pfsr_pkg::NPAD))) begin
      next_st.fsel[pad_cfg_idx] = pad_cfg_fsel;
      next_st.drive[pad_cfg_idx] = pad_cfg_drive;
      next_st.ie[pad_cfg_idx] = pad_cfg_ie;
      // input-only pads have no pull circuitry
      next_st.pu[pad_cfg_idx] = pad_cfg_pu & ~pfsr_pkg::IN_ONLY_MASK[pad_cfg_idx];
      next_st.pd[pad_cfg_idx] = pad_cfg_pd & ~pfsr_pkg::IN_ONLY_MASK[pad_cfg_idx];
      next_st.route_en[pad_cfg_idx] = pad_cfg_route_en;
      next_st.route_sig[pad_cfg_idx] = pad_cfg_route_sig;
      next_st.wake_en[pad_cfg_idx] = pad_cfg_wake_en;
    end
    // one routed input's configuration per write
    if (sig_cfg_wr) begin
      next_st.in_sel[sig_cfg_idx] = routed_input_select;
      next_st.in_inv[sig_cfg_idx] = routed_input_invert;
      next_st.in_route[sig_cfg_idx] = sig_cfg_route;
    end
    // regulator voltage: software write wins, else catch strap or forced fuse once
    if (vsel_wr) begin
      next_st.vsel = vsel_val;
      next_st.vsel_taken = 1'b1;
    end else if (!st.vsel_taken) begin
      next_st.vsel = fuse_force ? fuse_vsel : strap_vsel;
      next_st.vsel_taken = 1'b1;
    end
    // pad drivers and direct peripheral inputs
    for (int p = 0; p < pfsr_pkg::NPAD; p++) begin
      f = st.fsel[p];
      if (st.route_en[p]) begin
        // matrix signal drives the pad, any signal to any pad except input-only pads 34 to 39
        o = sig_out[st.route_sig[p]];
        oe = sig_oe[st.route_sig[p]];
      end else if (f <= pfsr_pkg::FSEL_MAX) begin
        // selected function owns the pad
        o = func_out[p][f];
        oe = func_oe[p][f] & pfsr_pkg::has_out(PAD_FTYPE[p][f]);
      end else begin
        // no function selected
        o = 1'b0;
        oe = 1'b0;
      end
      if (pfsr_pkg::IN_ONLY_MASK[p]) begin
        oe = 1'b0;
      end
      if (deep_sleep && !pfsr_pkg::AON_MASK[p]) begin
        oe = 1'b0;
      end
      next_st.out[p] = o;
      next_st.oe_n[p] = ~oe;
      for (int k = 0; k < pfsr_pkg::NFUNC; k++) begin
        next_st.fin[p][k] = pfsr_pkg::fin_value(PAD_FTYPE[p][k],
          (st.route_en[p] == 1'b0) && (f == pfsr_pkg::FSEL_W'(k)), pad_in[p]);
      end
    end
    next_st.routed = route_val;
    // wake only from always-on pads while asleep
    next_st.wake = deep_sleep & (|(pad_in & st.wake_en & pfsr_pkg::AON_MASK));
  end

  // state register, held at reset values while reset stands
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= pfsr_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign pad_out = st.out;
  assign pad_oe_n = st.oe_n;
  assign pad_ie = st.ie;
  assign pad_pu = st.pu;
  assign pad_pd = st.pd;
  assign pad_drive = st.drive;
  assign func_in = st.fin;
  assign routed_in = st.routed;
  assign io_supply_regulator_sel = st.vsel;
  assign wake = st.wake;

  // checks on the design's own behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic pick7; // matrix signal chosen for pad 7
  assign pick7 = sig_out[st.route_sig[7]];

  property p_oe_off_in_reset;
    !rst_n |-> (&pad_oe_n) && (pad_ie == pfsr_pkg::IE_RESET) && (pad_pu == pfsr_pkg::PU_RESET);
  endproperty
  a_oe_off_in_reset: assert property (p_oe_off_in_reset) else $error("pad driven in reset");

  property p_drive_after_reset;
    $rose(rst_n) |-> (pad_drive == {pfsr_pkg::NPAD{pfsr_pkg::DRV_RESET}});
  endproperty
  a_drive_after_reset: assert property (p_drive_after_reset) else $error("drive not two");

  property p_func1_drives;
    rst_n && (st.fsel[0] == pfsr_pkg::FSEL_RESET) && !st.route_en[0] && func_oe[0][0] &&
      pfsr_pkg::has_out(PAD_FTYPE[0][0]) && !deep_sleep |=> !pad_oe_n[0] || !rst_n;
  endproperty
  a_func1_drives: assert property (p_func1_drives) else $error("function one not driving");

  property p_input_only;
    (&pad_oe_n[39:34]) && !(|pad_pu[39:34]) && !(|pad_pd[39:34]);
  endproperty
  a_input_only: assert property (p_input_only) else $error("input-only pad driven");

  property p_bad_fsel;
    rst_n && (st.fsel[3] > pfsr_pkg::FSEL_MAX) && !st.route_en[3] |=> pad_oe_n[3];
  endproperty
  a_bad_fsel: assert property (p_bad_fsel) else $error("invalid select drives");

  property p_matrix_out;
    rst_n && st.route_en[7] |=> (pad_out[7] == $past(pick7)) || !rst_n;
  endproperty
  a_matrix_out: assert property (p_matrix_out) else $error("matrix output wrong");

  property p_unassigned;
    rst_n && st.in_route[29] && (st.in_sel[29] >= pfsr_pkg::PAD_W'(pfsr_pkg::NPAD)) &&
      !st.in_inv[29] |=> (routed_in[29] == pfsr_pkg::SIG_DEFAULT[29]) || !rst_n;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned input wrong");

  property p_vsel_override;
    rst_n && vsel_wr |=> (io_supply_regulator_sel == $past(vsel_val)) || !rst_n;
  endproperty
  a_vsel_override: assert property (p_vsel_override) else $error("voltage override lost");

  property p_wake;
    rst_n && deep_sleep && (|(pad_in & st.wake_en & pfsr_pkg::AON_MASK)) |=> wake || !rst_n;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  // unselected-function input values for every pad's default-high, default-low and plain input functions
  for (genvar gp = 0; gp < pfsr_pkg::NPAD; gp++) begin : g_chk_pad
    for (genvar gf = 0; gf < pfsr_pkg::NFUNC; gf++) begin : g_chk_fn
      if (PAD_FTYPE[gp][gf] == pfsr_pkg::input_default_high_type ||
          PAD_FTYPE[gp][gf] == pfsr_pkg::bidir_default_high_type) begin : g_hi
        property p_hi;
          rst_n && (st.fsel[gp] != pfsr_pkg::FSEL_W'(gf)) |=> func_in[gp][gf] || !rst_n;
        endproperty
        a_hi: assert property (p_hi) else $error("default-high input not one");
      end else if (PAD_FTYPE[gp][gf] == pfsr_pkg::ft_input_default_low) begin : g_lo
        property p_lo;
          rst_n && (st.fsel[gp] != pfsr_pkg::FSEL_W'(gf)) |=> !func_in[gp][gf] || !rst_n;
        endproperty
        a_lo: assert property (p_lo) else $error("default-low input not zero");
      end else if (PAD_FTYPE[gp][gf] == pfsr_pkg::ft_input) begin : g_in
        property p_in;
          rst_n |=> (func_in[gp][gf] == $past(pad_in[gp])) || !rst_n;
        endproperty
        a_in: assert property (p_in) else $error("plain input not from pad");
      end
    end
  end

endmodule

`default_nettype wire

/* pfsr_pkg.sv */
package pfsr_pkg;

  // pad, function and signal counts
  localparam int NPAD = 40; // general-purpose pads
  localparam int NFUNC = 6; // digital functions per pad
  localparam int NSIG = 256; // routed peripheral signals
  localparam int FSEL_W = 3; // function-select width
  localparam int DRV_W = 2; // drive strength width
  localparam int PAD_W = 6; // pad index width
  localparam int SIG_W = 8; // signal index width

  // function-select codes
  localparam logic [FSEL_W-1:0] FSEL_RESET = 3'h0; // function 1
  localparam logic [FSEL_W-1:0] FSEL_MAX = 3'h5; // function 6, above is no function
  localparam logic [FSEL_W-1:0] DIRECT_FSEL = 3'h0; // direct path of dual-path inputs

  // drive strength: 0 ~5 mA, 1 ~10 mA, 2 ~20 mA, 3 ~40 mA
  localparam logic [DRV_W-1:0] DRV_RESET = 2'h2;

  // routed input select value meaning no pad
  localparam logic [PAD_W-1:0] PAD_NONE = 6'h3F;

  // per-pad reset values and pad classes
  localparam logic [NPAD-1:0] IE_RESET = 40'hFF_FFFF_FFFF; // input enable
  localparam logic [NPAD-1:0] PU_RESET = 40'h00_0000_0000; // weak pull-up
  localparam logic [NPAD-1:0] PD_RESET = 40'h00_0000_0000; // weak pull-down
  localparam logic [NPAD-1:0] IN_ONLY_MASK = 40'hFC_0000_0000; // pads 34 to 39
  localparam logic [NPAD-1:0] AON_MASK = 40'hFF_0000_F00F; // always-on domain pads

  // per-signal defaults when no pad drives a routed input
  localparam logic [NSIG-1:0] SIG_DEFAULT = 256'h6000_0000;
  // signals that also have a direct pad path
  localparam logic [NSIG-1:0] SIG_BOTH = 256'h0006_FF3F;

  // kind of each pad function
  typedef enum logic [2:0] {
    ft_input, // input, still fed from the pad when unselected
    input_default_high_type, // input, one when unselected
    ft_input_default_low, // input, zero when unselected
    ft_output, // output only
    ft_bidir, // input, output and tri-state
    bidir_default_high_type // bidir, input one when unselected
  } pfsr_ftype_e;

  // whole registered state of the pad mux
  typedef struct packed {
    logic [NPAD-1:0][FSEL_W-1:0] fsel; // selected function minus one
    logic [NPAD-1:0][DRV_W-1:0] drive; // drive strength codes
    logic [NPAD-1:0] ie; // input enables
    logic [NPAD-1:0] pu; // weak pull-ups
    logic [NPAD-1:0] pd; // weak pull-downs
    logic [NPAD-1:0] route_en; // pad output from matrix
    logic [NPAD-1:0] wake_en; // wake source enables
    logic [NPAD-1:0][SIG_W-1:0] route_sig; // matrix signal per pad
    logic [NSIG-1:0][PAD_W-1:0] in_sel; // pad per routed input
    logic [NSIG-1:0] in_inv; // invert per routed input
    logic [NSIG-1:0] in_route; // routed input through matrix
    logic vsel; // regulator at 1.8 V when set
    logic vsel_taken; // strap default already caught
    logic [NPAD-1:0] out; // pad output values
    logic [NPAD-1:0] oe_n; // pad output enables, low drives
    logic [NPAD-1:0][NFUNC-1:0] fin; // direct peripheral inputs
    logic [NSIG-1:0] routed; // routed peripheral inputs
    logic wake; // wake request
  } pfsr_state_s;

  localparam pfsr_state_s STATE_RESET = '{
    fsel: {NPAD{FSEL_RESET}},
    drive: {NPAD{DRV_RESET}},
    ie: IE_RESET,
    pu: PU_RESET,
    pd: PD_RESET,
    route_en: '0,
    wake_en: '0,
    route_sig: '0,
    in_sel: {NSIG{PAD_NONE}},
    in_inv: '0,
    in_route: '0,
    vsel: 1'b0,
    vsel_taken: 1'b0,
    out: '0,
    oe_n: '1,
    fin: '0,
    routed: '0,
    wake: 1'b0
  };

  // true for function kinds that can drive the pad
  function automatic logic has_out(input pfsr_ftype_e t);
    return (t == ft_output) || (t == ft_bidir) || (t == bidir_default_high_type);
  endfunction

  // value a peripheral sees on a direct function input
  function automatic logic fin_value(input pfsr_ftype_e t, input logic sel, input logic v);
    logic r;
    r = 1'b0;
    unique case (t)
      ft_input, ft_bidir: r = v;
      input_default_high_type, bidir_default_high_type: r = sel ? v : 1'b1;
      ft_input_default_low: r = sel ? v : 1'b0;
      ft_output: r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

/* pfsr_route_in.sv */
`timescale 1ns/10ps
`default_nettype none

// picks the value one routed peripheral input sees
module pfsr_route_in (
  input wire logic [pfsr_pkg::NPAD-1:0] pad_in, // pad levels
  input wire logic [pfsr_pkg::PAD_W-1:0] sel, // pad chosen for this input
  input wire logic inv, // invert the result
  input wire logic route_en, // take the matrix path
  input wire logic both_path, // signal also has a direct path
  input wire logic dflt, // value when no pad is assigned
  input wire logic direct_val, // value over the direct path
  output logic val // value seen by the peripheral
);

  // matrix pad, direct path or default, then optional inversion
  always_comb begin
    logic raw;
    raw = dflt;
    if (route_en && (sel < pfsr_pkg::PAD_W'(pfsr_pkg::NPAD))) begin
      raw = pad_in[sel];
    end else if (!route_en && both_path) begin
      raw = direct_val;
    end else begin
      raw = dflt;
    end
    val = raw ^ inv;
  end

endmodule

`default_nettype wire

/* pfsr_pad_model.sv */
`timescale 1ns/10ps
`default_nettype none

// external pad wiring: resolves each pad from the chip driver, an outside driver and pulls
module pfsr_pad_model (
  input wire logic clock, // system clock
  input wire logic [pfsr_pkg::NPAD-1:0] pad_out, // chip output levels
  input wire logic [pfsr_pkg::NPAD-1:0] pad_oe_n, // chip enables, low drives
  input wire logic [pfsr_pkg::NPAD-1:0] pad_pu, // chip weak pull-ups
  input wire logic [pfsr_pkg::NPAD-1:0] pad_pd, // chip weak pull-downs
  input wire logic [pfsr_pkg::NPAD-1:0] ext_en, // outside driver active
  input wire logic [pfsr_pkg::NPAD-1:0] ext_val, // outside driver level
  output logic [pfsr_pkg::NPAD-1:0] pad_in // resolved pad levels
);
  logic [pfsr_pkg::NPAD-1:0] held; // last resolved level

  // remember levels so a floating pad can toggle instead of settling to a guess
  always @(posedge clock) begin
    held <= pad_in;
  end

  // chip driver wins, then outside driver, then pulls, else a changing level
  always_comb begin
    for (int i = 0; i < pfsr_pkg::NPAD; i++) begin
      if (pad_oe_n[i] === 1'b0) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pu[i] === 1'b1) begin
        pad_in[i] = 1'b1;
      end else if (pad_pd[i] === 1'b1) begin
        pad_in[i] = 1'b0;
      end else begin
        pad_in[i] = (held[i] === 1'b1) ? 1'b0 : 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

/* pfsr_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

// self-checking bench for the pad function mux
module pfsr_tb_top;
  // function kinds of pad 0 cover every kind, all other pads bidirectional
  localparam pfsr_pkg::pfsr_ftype_e [pfsr_pkg::NPAD-1:0][pfsr_pkg::NFUNC-1:0] FTYPE = '{
    0: '{0: pfsr_pkg::ft_bidir, 1: pfsr_pkg::input_default_high_type,
         2: pfsr_pkg::ft_input_default_low, 3: pfsr_pkg::ft_input,
         4: pfsr_pkg::bidir_default_high_type, 5: pfsr_pkg::ft_output},
    default: '{default: pfsr_pkg::ft_bidir}};
  logic clock = 1'b0; // system clock
  logic nrst = 1'b0; // reset, active low
  logic pad_cfg_wr = 1'b0, pad_cfg_ie, pad_cfg_pu, pad_cfg_pd, pad_cfg_route_en, pad_cfg_wake_en;
  logic [5:0] pad_cfg_idx; // pad number
  logic [2:0] pad_cfg_fsel; // function minus one
  logic [1:0] pad_cfg_drive; // drive code
  logic [7:0] pad_cfg_route_sig, sig_cfg_idx; // matrix signal numbers
  logic sig_cfg_wr = 1'b0, routed_input_invert, sig_cfg_route; // signal write
  logic [5:0] routed_input_select; // pad per routed input
  logic strap_vsel = 1'b1, fuse_force = 1'b0, fuse_vsel = 1'b0; // voltage straps
  logic vsel_wr = 1'b0, vsel_val = 1'b0, deep_sleep = 1'b0; // override and sleep
  logic [39:0] pad_in, pad_out, pad_oe_n, pad_ie, pad_pu, pad_pd; // pad side
  logic [39:0] ext_en = '0, ext_val = '0; // outside drivers
  logic [39:0][1:0] pad_drive; // drive codes
  logic [39:0][5:0] func_out = '0, func_oe = '0, func_in; // direct peripheral side
  logic [255:0] sig_out = '0, sig_oe = '0, routed_in; // matrix peripheral side
  logic io_supply_regulator_sel, wake; // regulator choice and wake
  int error_cnt = 0; // mismatches
  int check_count = 0; // comparisons

  // clock at 10 MHz
  always #50 clock = ~clock;

  pfsr_top #(.PAD_FTYPE(FTYPE)) i_pfsr_top (.clock(clock), .nrst(nrst),
    .pad_cfg_wr(pad_cfg_wr), .pad_cfg_idx(pad_cfg_idx), .pad_cfg_fsel(pad_cfg_fsel),
    .pad_cfg_drive(pad_cfg_drive), .pad_cfg_ie(pad_cfg_ie), .pad_cfg_pu(pad_cfg_pu),
    .pad_cfg_pd(pad_cfg_pd), .pad_cfg_route_en(pad_cfg_route_en),
    .pad_cfg_route_sig(pad_cfg_route_sig), .pad_cfg_wake_en(pad_cfg_wake_en),
    .sig_cfg_wr(sig_cfg_wr), .sig_cfg_idx(sig_cfg_idx),
    .routed_input_select(routed_input_select), .routed_input_invert(routed_input_invert),
    .sig_cfg_route(sig_cfg_route), .strap_vsel(strap_vsel), .fuse_force(fuse_force),
    .fuse_vsel(fuse_vsel), .vsel_wr(vsel_wr), .vsel_val(vsel_val), .deep_sleep(deep_sleep),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_ie(pad_ie),
    .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_drive(pad_drive), .func_out(func_out),
    .func_oe(func_oe), .func_in(func_in), .sig_out(sig_out), .sig_oe(sig_oe),
    .routed_in(routed_in), .io_supply_regulator_sel(io_supply_regulator_sel), .wake(wake));

  pfsr_pad_model i_pfsr_pad_model (.clock(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pu(pad_pu), .pad_pd(pad_pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // compare one value and count it
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one pad configuration write, strobe for one cycle
  task automatic cfg_pad(input int idx, input int fsel, input int drv, input logic pu,
                         input logic ren, input int rsig, input logic wen);
    @(negedge clock);
    pad_cfg_wr = 1'b1;
    pad_cfg_idx = 6'(idx);
    pad_cfg_fsel = 3'(fsel);
    pad_cfg_drive = 2'(drv);
    pad_cfg_ie = 1'b1;
    pad_cfg_pu = pu;
    pad_cfg_pd = 1'b0;
    pad_cfg_route_en = ren;
    pad_cfg_route_sig = 8'(rsig);
    pad_cfg_wake_en = wen;
    @(negedge clock);
    pad_cfg_wr = 1'b0;
  endtask

  // one routed input configuration write
  task automatic cfg_sig(input int idx, input int sel, input logic inv, input logic rte);
    @(negedge clock);
    sig_cfg_wr = 1'b1;
    sig_cfg_idx = 8'(idx);
    routed_input_select = 6'(sel);
    routed_input_invert = inv;
    sig_cfg_route = rte;
    @(negedge clock);
    sig_cfg_wr = 1'b0;
  endtask

  // let registered outputs catch up
  task automatic settle();
    repeat (2) @(negedge clock);
  endtask

  // print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the tests need well under 2000 cycles
  initial begin
    #(20000 * 100);
    error_cnt++;
    wrap_up();
  end

  // main test sequence
  initial begin
    // function 1 of every pad drives its pad number's low bit
    for (int p = 0; p < 40; p++) begin
      func_out[p][0] = p[0];
      func_oe[p][0] = 1'b1;
    end
    repeat (3) @(negedge clock);
    chk("oe_n in reset", 64'hFF_FFFF_FFFF, 64'(pad_oe_n));
    chk("ie in reset", 64'(pfsr_pkg::IE_RESET), 64'(pad_ie));
    chk("pulls in reset", 64'h0, 64'(pad_pu | pad_pd));
    chk("drive in reset", 64'hAAAA_AAAA_AAAA_AAAA, 64'(pad_drive));
    @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    chk("oe_n after reset", 64'hFC_0000_0000, 64'(pad_oe_n));
    chk("out after reset", 64'h02_AAAA_AAAA, 64'(pad_out & 40'h03_FFFF_FFFF));
    chk("strap voltage", 64'h1, 64'(io_supply_regulator_sel));
    // software override of regulator voltage
    @(negedge clock);
    vsel_wr = 1'b1;
    @(negedge clock);
    vsel_wr = 1'b0;
    settle();
    chk("software voltage", 64'h0, 64'(io_supply_regulator_sel));
    // input-only pad: enable and pull-up refused
    func_oe[35] = 6'h3F;
    cfg_pad(35, 0, 1, 1'b1, 1'b0, 0, 1'b0);
    settle();
    chk("pad 35 pull-up", 64'h0, 64'(pad_pu[35]));
    chk("pad 35 oe_n", 64'h1, 64'(pad_oe_n[35]));
    // every select code and drive code on pad 3
    func_out[3] = 6'h2A;
    func_oe[3] = 6'h3F;
    for (int f = 0; f < 8; f++) begin
      cfg_pad(3, f, f % 4, 1'b0, 1'b0, 0, 1'b0);
      settle();
      chk("pad 3 drive", 64'(f % 4), 64'(pad_drive[3]));
      chk("pad 3 oe_n", (f > 5) ? 64'h1 : 64'h0, 64'(pad_oe_n[3]));
      if (f < 6) begin
        chk("pad 3 out", 64'(func_out[3][f]), 64'(pad_out[3]));
      end
    end
    // unselected input kinds on pad 0, outside driver toggling the pad
    ext_en[0] = 1'b1;
    for (int s = 5; s > 0; s -= 4) begin
      cfg_pad(0, s, 2, 1'b0, 1'b0, 0, 1'b0);
      for (int v = 0; v < 2; v++) begin
        ext_val[0] = v[0];
        settle();
        chk("bidir input", 64'(v), 64'(func_in[0][0]));
        chk("default high", (s == 1) ? 64'(v) : 64'h1, 64'(func_in[0][1]));
        chk("default low", 64'h0, 64'(func_in[0][2]));
        chk("plain input", 64'(v), 64'(func_in[0][3]));
        chk("bidir high", 64'h1, 64'(func_in[0][4]));
      end
    end
    // host command line owned by its function when selected
    func_out[0][4] = 1'b1;
    func_oe[0][4] = 1'b1;
    cfg_pad(0, 4, 2, 1'b0, 1'b0, 0, 1'b0);
    settle();
    chk("bidir high drives", 64'h0, 64'(pad_oe_n[0]));
    chk("bidir high out", 64'h1, 64'(pad_out[0]));
    func_oe[0][4] = 1'b0;
    // matrix output on pad 7 from signal 200
    sig_out[200] = 1'b1;
    sig_oe[200] = 1'b1;
    cfg_pad(7, 0, 2, 1'b0, 1'b1, 200, 1'b0);
    settle();
    chk("matrix out", 64'h1, 64'(pad_out[7]));
    chk("matrix oe_n", 64'h0, 64'(pad_oe_n[7]));
    sig_oe[200] = 1'b0;
    settle();
    chk("matrix oe_n off", 64'h1, 64'(pad_oe_n[7]));
    // routed inputs: matrix path with invert, direct path, unassigned defaults
    cfg_sig(2, 9, 1'b1, 1'b1);
    cfg_sig(3, 10, 1'b0, 1'b0);
    cfg_sig(29, 63, 1'b0, 1'b1);
    settle();
    chk("routed 2", 64'h0, 64'(routed_in[2]));
    chk("direct 3", 64'h0, 64'(routed_in[3]));
    chk("default 29", 64'h1, 64'(routed_in[29]));
    chk("default 6", 64'h0, 64'(routed_in[6]));
    func_out[9][0] = 1'b0;
    func_out[10][0] = 1'b1;
    cfg_sig(29, 63, 1'b1, 1'b1);
    settle();
    chk("routed 2 flip", 64'h1, 64'(routed_in[2]));
    chk("direct 3 flip", 64'h1, 64'(routed_in[3]));
    chk("default 29 inv", 64'h0, 64'(routed_in[29]));
    // deep sleep: always-on pad wakes, others stop driving
    ext_val[0] = 1'b1;
    cfg_pad(0, 5, 2, 1'b0, 1'b0, 0, 1'b1);
    deep_sleep = 1'b1;
    settle();
    chk("wake", 64'h1, 64'(wake));
    chk("sleep pad 20", 64'h1, 64'(pad_oe_n[20]));
    chk("sleep pad 12", 64'h0, 64'(pad_oe_n[12]));
    deep_sleep = 1'b0;
    settle();
    chk("awake", 64'h0, 64'(wake));
    wrap_up();
  end
endmodule

`default_nettype wire
